// *** hdl/lds_crc.sv ***
// Purpose: 6-bit checksum remainder of the configuration word
// Assumes: word is held stable by the caller
// Notes:   purely combinational long division, msb first
`timescale 1ns/1ps
`default_nettype none
module lds_crc
	import lds_pkg::*;
(
	input  wire logic [lds_pkg::CFG_W-1:0] word_in, // configuration word
	output logic      [lds_pkg::CRC_W-1:0] crc_out  // remainder
);

	// feedback form over the word bits alone equals dividing word plus zeros
	always_comb begin
		logic [CRC_W-1:0] rem;
		logic [DATA_W-1:0] data;
		logic              fb;
		rem  = '0;
		data = {word_in, {CRC_W{1'b0}}};
		fb   = 1'b0;
		for (int i = DATA_W - 1; i >= CRC_W; i--) begin
			fb  = rem[CRC_W-1] ^ data[i];
			rem = {rem[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY_LOW : '0); // see RL8
		end
		crc_out = rem;
	end

endmodule : lds_crc
`default_nettype wire

// *** hdl/lds_pkg.sv ***
// Purpose: shared constants and types for the led driver serial register bank
// Assumes: 24-bit configuration and fault words, 8 channel pairs
// Notes:   fault word pair flags are open (upper) then short (lower)
package lds_pkg;

	// word and field sizes
	localparam int unsigned CFG_W   = 24;
	localparam int unsigned PAIRS   = 8;
	localparam int unsigned CHANS   = 16;
	localparam int unsigned CRC_W   = 6;
	localparam int unsigned DATA_W  = CFG_W + CRC_W;

	// register offsets on the serial link
	localparam logic [0:0] CFG_OFS = 1'h0;
	localparam logic [0:0] FLT_OFS = 1'h1;

	// checksum divisor, full 7 bits and the part below the leading one
	localparam logic [6:0]       CRC_POLY     = 7'h43;
	localparam logic [CRC_W-1:0] CRC_POLY_LOW = CRC_POLY[CRC_W-1:0];

	// fault word bit positions
	localparam int unsigned FLT_OT_BIT   = 7;
	localparam int unsigned FLT_CONF_BIT = 6;
	localparam int unsigned FLT_PAIR_LSB = 8;

	// index of each synchronised pin in the input bundle
	localparam int unsigned SI_SCLK  = 0;
	localparam int unsigned SI_LCLK  = 1;
	localparam int unsigned SI_SDI   = 2;
	localparam int unsigned SI_CLRN  = 3;
	localparam int unsigned SI_EN    = 4;
	localparam int unsigned SI_PG    = 5;
	localparam int unsigned SI_G1N   = 6;
	localparam int unsigned SI_G2N   = 7;
	localparam int unsigned SI_OT    = 8;
	localparam int unsigned SI_OPEN  = 9;
	localparam int unsigned SI_SHORT = SI_OPEN + PAIRS;
	localparam int unsigned SI_W     = SI_SHORT + PAIRS;

	// configuration word: diag selects on top, channel switches below
	typedef struct packed {
		logic [PAIRS-1:0] pair_diag_select;
		logic [CHANS-1:0] channel_switch_on;
	} lds_cfg_s;

	localparam lds_cfg_s CFG_RESET = '0;

	// fault word as shifted out, msb first
	typedef struct packed {
		logic [PAIRS-1:0][1:0] pair_flags; // [1] open, [0] short
		logic                  overtemp_flag;
		logic                  conflict_flag;
		logic [CRC_W-1:0]      crc;
	} lds_fault_s;

	// whole state of the register bank
	typedef struct packed {
		logic [CFG_W-1:0] shift_chain;
		lds_cfg_s         storage;
		logic [CFG_W-1:0] out_chain;
		logic [PAIRS-1:0] open_flag;
		logic [PAIRS-1:0] short_flag;
		logic             overtemp_flag;
		logic             conflict_flag;
		logic [CHANS-1:0] chan_on;
		logic [PAIRS-1:0] diag_on;
		logic             readback;
		logic             fault_oe;
	} lds_state_s;

	localparam lds_state_s STATE_RESET = '0;

endpackage : lds_pkg

// *** hdl/lds_regs.sv ***
// Purpose: serial configuration and fault readback of a 16-channel sink driver
// Assumes: shift and latch clocks far slower than clk_in, sampled as pins
// Notes:   every pin passes two flops; state updates a cycle after the edge
`timescale 1ns/1ps
`default_nettype none

// Contract
// RL1 - 24-bit word shifts in on shift rise, copied to storage on latch rise
// RL2 - first eight bits pick pair diagnostics, next sixteen switch channels
// RL3 - bits 23..16 each make a pair's second pin a diagnostics input
// RL4 - diag select plus second channel on: run as output, flag conflict
// RL5 - latch rise loads fault word, msb appears on readback line
// RL6 - each shift fall moves one more fault bit out, 24 in total
// RL7 - readback carries 6-bit checksum of the shift chain contents
// RL8 - checksum is remainder of word plus six zeros divided by 0x43
// RL9 - host divides word plus checksum, zero remainder means good link
// RL10 - checksum work never alters shift or storage configuration
// RL11 - clear input low resets every register to default
// RL12 - host should pulse clear at power-up or initialisation
// RL13 - each group gate low lets stored values reach its eight channels
// RL14 - supply rising past power-on threshold starts from defaults
// RL15 - enable high enters standby with all registers at default
// RL16 - read-to-clear flags drop after readout once cause is gone
// RL17 - bits 15..0 each switch one channel's low-side switch on
// RL18 - any flag set pulls the open-drain fault pin low
// RL19 - host clears conflict by fixing configuration then reading faults
// RL20 - one 24-clock train writes configuration and reads faults together
// RL21 - checksum in bits 5..0, thermal at bit 7, conflict at bit 6
module lds_regs
	import lds_pkg::*;
(
	input  wire logic                  clk_in,                // 100 MHz clock
	input  wire logic                  rst_in,                // sync reset, high
	input  wire logic                  shift_clock_in,        // shift clock pin
	input  wire logic                  latch_clock_in,        // latch clock pin
	input  wire logic                  serial_data_in,        // serial data pin
	input  wire logic                  register_clear_n_in,   // clear, low
	input  wire logic                  standby_in,            // enable pin, high=standby
	input  wire logic                  supply_ok_in,          // above power-on level
	input  wire logic                  low_group_gate_n_in,   // gate ch 0..7, low
	input  wire logic                  high_group_gate_n_in,  // gate ch 8..15, low
	input  wire logic                  overtemp_in,           // thermal sensor
	input  wire logic [PAIRS-1:0]      open_detect_in,        // open comparators
	input  wire logic [PAIRS-1:0]      short_detect_in,       // short comparators
	output logic      [CHANS-1:0]      channel_switch_on_out, // switch drive
	output logic      [PAIRS-1:0]      pair_diag_select_out,  // pair in diag mode
	output logic                       readback_line_out,     // serial out pin
	output logic                       fault_pin_out,         // fault pin level
	output logic                       fault_pin_oe_out       // fault pin drive
);

	lds_state_s      st_q;
	lds_state_s      st_d;
	logic [SI_W-1:0] raw;
	logic [SI_W-1:0] lvl;
	logic [SI_W-1:0] rise;
	logic [SI_W-1:0] fall;
	logic [CRC_W-1:0] crc;
	logic             sclk_rise;
	logic             sclk_fall;
	logic             lclk_rise;
	logic             clear_all;
	logic [PAIRS-1:0] conflict_vec;
	logic [PAIRS-1:0] diag_eff;
	lds_fault_s       fault_word;

	// bundle every pin for the synchroniser
	assign raw = {short_detect_in, open_detect_in, overtemp_in,
		high_group_gate_n_in, low_group_gate_n_in, supply_ok_in,
		standby_in, register_clear_n_in, serial_data_in,
		latch_clock_in, shift_clock_in};

	lds_sync #(
		.W (SI_W)
	) u_sync (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.async_in  (raw),
		.level_out (lvl),
		.rise_out  (rise),
		.fall_out  (fall)
	);

	assign sclk_fall = fall[SI_SCLK];
	assign sclk_rise = rise[SI_SCLK];
	assign lclk_rise = rise[SI_LCLK];

	// checksum of what sits in the shift chain, read only
	lds_crc u_crc (
		.word_in (st_q.shift_chain),
		.crc_out (crc)  // see RL7 RL10
	);

	// clear, power-on and standby all force defaults
	assign clear_all = ~lvl[SI_CLRN] | lvl[SI_EN] | ~lvl[SI_PG]; // see RL11 RL14 RL15

	// pair decode of the stored configuration
	always_comb begin
		for (int p = 0; p < PAIRS; p++) begin
			conflict_vec[p] = st_q.storage.pair_diag_select[p]
				& st_q.storage.channel_switch_on[2*p+1]; // see RL4
			diag_eff[p] = st_q.storage.pair_diag_select[p]
				& ~st_q.storage.channel_switch_on[2*p+1]; // see RL3
		end
	end

	// fault word as loaded at the latch edge
	always_comb begin
		fault_word = '0;
		for (int p = 0; p < PAIRS; p++) begin
			fault_word.pair_flags[p] = {st_q.open_flag[p], st_q.short_flag[p]};
		end
		fault_word.overtemp_flag = st_q.overtemp_flag; // see RL21
		fault_word.conflict_flag = st_q.conflict_flag; // see RL21
		fault_word.crc           = crc;                // see RL21
	end

	// next state of the whole bank
	always_comb begin
		logic cond;
		st_d = st_q;
		cond = 1'b0;
		// serial in, first bit ends at the msb
		if (sclk_rise) begin
			st_d.shift_chain = {st_q.shift_chain[CFG_W-2:0], lvl[SI_SDI]}; // see RL1 RL2
		end
		if (lclk_rise) begin
			st_d.storage = lds_cfg_s'(st_q.shift_chain); // see RL1
		end
		// serial out: load wins over a shift in the same cycle
		if (lclk_rise) begin
			st_d.out_chain = fault_word; // see RL5
		end else if (sclk_fall) begin
			st_d.out_chain = {st_q.out_chain[CFG_W-2:0], 1'b0}; // see RL6 RL20
		end
		// sticky flags, set beats the read clear
		for (int p = 0; p < PAIRS; p++) begin
			cond = lvl[SI_OPEN+p] & diag_eff[p]
				& st_q.storage.channel_switch_on[2*p];
			st_d.open_flag[p] = cond | (st_q.open_flag[p] & ~lclk_rise); // see RL16
			cond = lvl[SI_SHORT+p] & diag_eff[p]
				& st_q.storage.channel_switch_on[2*p];
			st_d.short_flag[p] = cond | (st_q.short_flag[p] & ~lclk_rise); // see RL16
		end
		st_d.overtemp_flag = lvl[SI_OT]
			| (st_q.overtemp_flag & ~lclk_rise); // see RL16
		st_d.conflict_flag = (|conflict_vec)
			| (st_q.conflict_flag & ~lclk_rise); // see RL4 RL16
		// channel drive, gated per group, off while overheated
		for (int c = 0; c < CHANS; c++) begin
			st_d.chan_on[c] = st_q.storage.channel_switch_on[c]
				& ~st_q.overtemp_flag
				& ~(c < CHANS/2 ? lvl[SI_G1N] : lvl[SI_G2N]); // see RL13 RL17
		end
		st_d.diag_on  = diag_eff;
		st_d.readback = st_d.out_chain[CFG_W-1]; // see RL5
		st_d.fault_oe = |{st_d.open_flag, st_d.short_flag,
			st_d.overtemp_flag, st_d.conflict_flag}; // see RL18
		if (clear_all) begin
			st_d = STATE_RESET; // see RL11 RL14 RL15
		end
	end

	// one register for the whole bank
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_q <= STATE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from the state register, fault pin level tied low
	assign channel_switch_on_out = st_q.chan_on;
	assign pair_diag_select_out  = st_q.diag_on;
	assign readback_line_out     = st_q.readback;
	assign fault_pin_out         = 1'b0;
	assign fault_pin_oe_out      = st_q.fault_oe;

	// checks
	property p_store;
		@(posedge clk_in) disable iff (rst_in)
		lclk_rise && !clear_all |=> st_q.storage == $past(st_q.shift_chain);
	endproperty
	a_store: assert property (p_store) else $error("storage missed chain"); // see RL1

	property p_msb;
		@(posedge clk_in) disable iff (rst_in)
		lclk_rise && !clear_all |=> readback_line_out == $past(fault_word[CFG_W-1]);
	endproperty
	a_msb: assert property (p_msb) else $error("fault msb not presented"); // see RL5

	property p_shift_out;
		@(posedge clk_in) disable iff (rst_in)
		sclk_fall && !lclk_rise && !clear_all
		|=> readback_line_out == $past(st_q.out_chain[CFG_W-2]);
	endproperty
	a_shift_out: assert property (p_shift_out) else $error("bad shift out"); // see RL6

	property p_conflict;
		@(posedge clk_in) disable iff (rst_in)
		(|conflict_vec) && !clear_all |=> st_q.conflict_flag && fault_pin_oe_out;
	endproperty
	a_conflict: assert property (p_conflict) else $error("conflict missed"); // see RL4

	property p_clear;
		@(posedge clk_in) disable iff (rst_in)
		clear_all |=> st_q == STATE_RESET;
	endproperty
	a_clear: assert property (p_clear) else $error("clear incomplete"); // see RL11

	property p_pin_free;
		@(posedge clk_in) disable iff (rst_in)
		!(|{st_q.open_flag, st_q.short_flag, st_q.overtemp_flag,
			st_q.conflict_flag}) |-> !fault_pin_oe_out;
	endproperty
	a_pin_free: assert property (p_pin_free) else $error("fault pin stuck"); // see RL18

	property p_gate;
		@(posedge clk_in) disable iff (rst_in)
		lvl[SI_G1N] |=> channel_switch_on_out[CHANS/2-1:0] == '0;
	endproperty
	a_gate: assert property (p_gate) else $error("low group not gated"); // see RL13

	property p_cfg_hold;
		@(posedge clk_in) disable iff (rst_in)
		!lclk_rise && !clear_all |=> $stable(st_q.storage);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("storage changed"); // see RL10

	property p_read_clear;
		@(posedge clk_in) disable iff (rst_in)
		lclk_rise && !lvl[SI_OT] && !clear_all |=> !st_q.overtemp_flag;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("flag kept"); // see RL16

	property p_shift_in;
		@(posedge clk_in) disable iff (rst_in)
		sclk_rise && !clear_all
		|=> st_q.shift_chain == {$past(st_q.shift_chain[CFG_W-2:0]),
			$past(lvl[SI_SDI])};
	endproperty
	a_shift_in: assert property (p_shift_in) // see RL1
		else $error("shift chain did not take data bit");

	property p_hi_gate;
		@(posedge clk_in) disable iff (rst_in)
		lvl[SI_G2N] |=> channel_switch_on_out[CHANS-1:CHANS/2] == '0;
	endproperty
	a_hi_gate: assert property (p_hi_gate) // see RL13
		else $error("high group not gated");

	property p_chan_on;
		@(posedge clk_in) disable iff (rst_in)
		!clear_all && !lvl[SI_G1N] && !st_q.overtemp_flag
		|=> channel_switch_on_out[CHANS/2-1:0]
			== $past(st_q.storage.channel_switch_on[CHANS/2-1:0]);
	endproperty
	a_chan_on: assert property (p_chan_on) // see RL17
		else $error("low group does not follow storage");

	property p_diag_on;
		@(posedge clk_in) disable iff (rst_in)
		st_q.storage.pair_diag_select[1] && !st_q.storage.channel_switch_on[3]
			&& !clear_all |=> pair_diag_select_out[1];
	endproperty
	a_diag_on: assert property (p_diag_on) // see RL3
		else $error("pair not in diagnostics");

	property p_conf_plain;
		@(posedge clk_in) disable iff (rst_in)
		st_q.storage.pair_diag_select[0] && st_q.storage.channel_switch_on[1]
			&& !clear_all |=> !pair_diag_select_out[0];
	endproperty
	a_conf_plain: assert property (p_conf_plain) // see RL4
		else $error("conflicting pair kept diagnostics");

	property p_rc_open;
		@(posedge clk_in) disable iff (rst_in)
		lclk_rise && !clear_all && (lvl[SI_OPEN +: PAIRS] == '0)
		|=> st_q.open_flag == '0;
	endproperty
	a_rc_open: assert property (p_rc_open) // see RL16
		else $error("open flag kept after readout");

	property p_rc_short;
		@(posedge clk_in) disable iff (rst_in)
		lclk_rise && !clear_all && (lvl[SI_SHORT +: PAIRS] == '0)
		|=> st_q.short_flag == '0;
	endproperty
	a_rc_short: assert property (p_rc_short) // see RL16
		else $error("short flag kept after readout");

	property p_word_fields;
		@(posedge clk_in) disable iff (rst_in)
		lclk_rise && !clear_all
		|=> st_q.out_chain[FLT_OT_BIT] == $past(st_q.overtemp_flag)
			&& st_q.out_chain[FLT_CONF_BIT] == $past(st_q.conflict_flag)
			&& st_q.out_chain[CRC_W-1:0] == $past(crc);
	endproperty
	a_word_fields: assert property (p_word_fields) // see RL21
		else $error("fault word fields misplaced");

	property p_fault_pin;
		@(posedge clk_in) disable iff (rst_in)
		|{st_q.open_flag, st_q.short_flag, st_q.overtemp_flag,
			st_q.conflict_flag} |-> fault_pin_oe_out;
	endproperty
	a_fault_pin: assert property (p_fault_pin) // see RL18
		else $error("fault pin not pulled");

	c_latch:    cover property (@(posedge clk_in) lclk_rise ##[1:200] sclk_fall);
	c_conflict: cover property (@(posedge clk_in) st_q.conflict_flag);
	c_diag:     cover property (@(posedge clk_in) |st_q.diag_on);
	c_pin:      cover property (@(posedge clk_in) fault_pin_oe_out);
	c_hot:      cover property (@(posedge clk_in) st_q.overtemp_flag);

endmodule : lds_regs
`default_nettype wire

// *** hdl/lds_sync.sv ***
// Purpose: two-flop synchroniser bank with edge detection
// Assumes: all inputs asynchronous to clk_in
// Notes:   edges come from the second and third stage only
`timescale 1ns/1ps
`default_nettype none
module lds_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_in,   // system clock
	input  wire logic         rst_in,   // sync reset, high
	input  wire logic [W-1:0] async_in, // raw pins
	output logic      [W-1:0] level_out, // synchronised level
	output logic      [W-1:0] rise_out,  // one-cycle rising pulse
	output logic      [W-1:0] fall_out   // one-cycle falling pulse
);

	// stage 0 is metastable, only stage 1 reads it
	logic [2:0][W-1:0] stage_q;
	logic [2:0][W-1:0] stage_d;

	// shift the pin through three stages
	always_comb begin
		stage_d = {stage_q[1], stage_q[0], async_in};
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			stage_q <= '0;
		end else begin
			stage_q <= stage_d;
		end
	end

	// edges from settled stages
	assign level_out = stage_q[1];
	assign rise_out  = stage_q[1] & ~stage_q[2];
	assign fall_out  = ~stage_q[1] & stage_q[2];

endmodule : lds_sync
`default_nettype wire

// *** sim/lds_host.sv ***
// Purpose: host model driving shift, latch and data pins of the register bank
// Assumes: 80 ns shift clock, pins changed only at falling clk_in edges
// Notes:   one call writes a word and reads the word loaded at the last latch
`timescale 1ns/1ps
`default_nettype none
module lds_host (
	input  wire logic clk_in,           // 100 MHz clock
	input  wire logic readback_line_in, // serial out of the block
	output var  logic shift_clock_out,  // shift clock pin
	output var  logic latch_clock_out,  // latch clock pin
	output var  logic serial_data_out   // serial data pin
);
	import lds_pkg::*;

	// clocks stand low outside frames
	initial begin
		shift_clock_out = 1'h0;
		latch_clock_out = 1'h0;
		serial_data_out = 1'h0;
	end

	// wait a number of falling edges
	task automatic idle(input int n);
		repeat (n) @(negedge clk_in);
	endtask : idle

	// long division by the divisor, msb first
	function automatic logic [CRC_W-1:0] rem30(input logic [DATA_W-1:0] w);
		logic [DATA_W-1:0] r;
		r = w;
		for (int i = DATA_W - 1; i >= CRC_W; i--) begin
			if (r[i]) begin
				r[i -: 7] = r[i -: 7] ^ CRC_POLY;
			end
		end
		return r[CRC_W-1:0];
	endfunction : rem30

	// one frame: 24 bits in on rises, 24 bits out before falls, then latch
	task automatic xfer(input logic [CFG_W-1:0] cfg,
		output logic [CFG_W-1:0] rd);
		rd = '0;
		for (int i = CFG_W - 1; i >= 0; i--) begin
			serial_data_out = cfg[i]; // msb first
			idle(4);
			shift_clock_out = 1'h1;
			idle(4);
			rd[i] = readback_line_in;
			shift_clock_out = 1'h0;
		end
		serial_data_out = ~cfg[0]; // line no longer holds the last bit
		idle(4);
		latch_clock_out = 1'h1;
		idle(4);
		latch_clock_out = 1'h0;
		idle(6);
	endtask : xfer

endmodule : lds_host
`default_nettype wire

// *** sim/led_driver_serial_regs_crc_test.sv ***
// Purpose: self-checking bench of the serial register bank
// Assumes: host model owns the link pins, bench owns the rest
// Notes:   expected words come from the divisor and the field layout
`timescale 1ns/1ps
`default_nettype none
module led_driver_serial_regs_crc_test;
	import lds_pkg::*;

	localparam logic [CFG_W-1:0] CFG_PLAIN = 24'h00a5c3;
	localparam logic [CFG_W-1:0] CFG_CONF  = 24'h030006;
	localparam logic [CFG_W-1:0] CFG_FIX   = 24'h020004;
	localparam int               LIMIT     = 12000;

	logic             clk_in, rst_in, clr_n, standby, supply_ok, ot;
	logic             g_lo_n, g_hi_n, shift, latch, sdata, rb, fpin, foe;
	logic [PAIRS-1:0] open_det, short_det, diag;
	logic [CHANS-1:0] chan;
	logic [CFG_W-1:0] rd;
	int               n_fail, n_checks, cycles;

	lds_host host (.clk_in(clk_in), .readback_line_in(rb),
		.shift_clock_out(shift), .latch_clock_out(latch),
		.serial_data_out(sdata));

	lds_regs dut (.clk_in(clk_in), .rst_in(rst_in), .shift_clock_in(shift),
		.latch_clock_in(latch), .serial_data_in(sdata),
		.register_clear_n_in(clr_n), .standby_in(standby),
		.supply_ok_in(supply_ok), .low_group_gate_n_in(g_lo_n),
		.high_group_gate_n_in(g_hi_n), .overtemp_in(ot),
		.open_detect_in(open_det), .short_detect_in(short_det),
		.channel_switch_on_out(chan), .pair_diag_select_out(diag),
		.readback_line_out(rb), .fault_pin_out(fpin),
		.fault_pin_oe_out(foe));

	// compare and count
	task automatic chk(input string what, input logic [CFG_W-1:0] seen,
		input logic [CFG_W-1:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// report and stop
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude

	function automatic logic [CFG_W-1:0] crc6(input logic [CFG_W-1:0] w);
		return {18'h0, host.rem30({w, 6'h0})};
	endfunction : crc6

	task automatic settle(input int n);
		repeat (n) @(negedge clk_in);
	endtask : settle

	// 100 MHz clock
	initial begin
		clk_in = 1'h0;
		forever #5 clk_in = ~clk_in;
	end

	// hang guard
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_fail++;
			conclude();
		end
	end

	// main sequence
	initial begin
		rst_in = 1'h1;
		clr_n = 1'h0; // clear held at start
		{standby, ot, g_lo_n, g_hi_n} = 4'h0;
		supply_ok = 1'h1;
		open_det = 8'h0;
		short_det = 8'h0;
		settle(8);
		rst_in = 1'h0;
		clr_n = 1'h1;
		settle(4);
		chk("outputs", {diag, chan}, 24'h0);
		chk("fault pin", {22'h0, fpin, foe}, 24'h0);
		host.xfer(CFG_PLAIN, rd);
		chk("first readback", rd, 24'h0);
		settle(4);
		chk("outputs", {diag, chan}, CFG_PLAIN);
		// group gates
		g_hi_n = 1'h1;
		settle(6);
		chk("high gated", {diag, chan}, 24'h0000c3);
		g_lo_n = 1'h1;
		g_hi_n = 1'h0;
		settle(6);
		chk("low gated", {diag, chan}, 24'h00a500);
		g_lo_n = 1'h0;
		// conflict on pair 0, pair 1 in diagnostics
		host.xfer(CFG_CONF, rd);
		chk("readback crc", rd, crc6(CFG_PLAIN));
		settle(4);
		chk("conflict outs", {diag, chan}, 24'h020006);
		chk("fault pin", {22'h0, fpin, foe}, 24'h1);
		open_det[1] = 1'h1;
		short_det[1] = 1'h1;
		settle(20);
		open_det[1] = 1'h0;
		short_det[1] = 1'h0;
		// a frame reads the word of the previous latch
		host.xfer(CFG_FIX, rd);
		chk("fix readback", rd, crc6(CFG_CONF));
		chk("host check", {18'h0, host.rem30({CFG_CONF, rd[5:0]})}, 24'h0);
		// thermal event
		ot = 1'h1;
		settle(8);
		chk("hot channels", {8'h0, chan}, 24'h0);
		ot = 1'h0;
		settle(4);
		host.xfer(CFG_FIX, rd);
		chk("flags", rd, 24'h000c40 | crc6(CFG_FIX));
		host.xfer(CFG_FIX, rd);
		chk("thermal", rd, 24'h0000c0 | crc6(CFG_FIX));
		host.xfer(CFG_FIX, rd);
		chk("cleared", rd, crc6(CFG_FIX));
		settle(4);
		chk("fault pin", {23'h0, foe}, 24'h0);
		// clear, standby and power-on each force defaults
		for (int k = 0; k < 3; k++) begin
			clr_n = (k != 0);
			standby = (k == 1);
			supply_ok = (k != 2);
			settle(6);
			chk("forced", {diag, chan}, 24'h0);
			{clr_n, standby, supply_ok} = 3'h5;
			settle(6);
			host.xfer(CFG_PLAIN, rd);
			chk("forced readback", rd, 24'h0);
			settle(4);
			chk("rewritten", {diag, chan}, CFG_PLAIN);
		end
		// worked example of the divisor
		host.xfer(24'hd70f68, rd);
		host.xfer(CFG_PLAIN, rd);
		chk("example crc", {18'h0, rd[5:0]}, 24'h19);
		conclude();
	end

endmodule : led_driver_serial_regs_crc_test
`default_nettype wire
